/* File: ppvc_params.svh */
// Constants for the power-management extension and product-data capability bank.
`ifndef PPVC_PARAMS_SVH
`define PPVC_PARAMS_SVH
`define PPVC_OFF_PM_CONTROL_STATUS 4'h4
`define PPVC_OFF_BSE 4'h6
`define PPVC_OFF_DATA 4'h7
`define PPVC_OFF_CAPID 4'h8
`define PPVC_OFF_NEXT 4'h9
`define PPVC_OFF_ADDR 4'ha
`define PPVC_OFF_WORD 4'hc
`define PPVC_CAPID_VAL 8'h03
`define PPVC_NEXT_VAL 8'h00
`define PPVC_BSE_RST 8'h00
`define PPVC_DATA_RST 8'h00
`define PPVC_BIT_BPCC 7
`define PPVC_BIT_B2B3 6
`define PPVC_FLAG_BIT 15
`define PPVC_PS_LO 0
`define PPVC_PS_HI 1
`define PPVC_DSEL_LO 9
`define PPVC_DSEL_HI 12
`define PPVC_DSCL_LO 13
`define PPVC_DSCL_HI 14
`define PPVC_PS_D0 2'h0
`define PPVC_PS_D1 2'h1
`define PPVC_PS_D2 2'h2
`define PPVC_PS_D3 2'h3
`endif

/* File: ppvc_pkg.sv */
// Types shared by the capability register bank.
package ppvc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] offset;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } ppvc_req_t;
  typedef struct packed {
    logic clock_stop;
    logic power_off;
    logic [1:0] bus_state;
  } ppvc_sec_t;
  typedef enum logic [3:0] {
    PPVC_B0 = 4'b0001,
    PPVC_B1 = 4'b0010,
    PPVC_B2 = 4'b0100,
    PPVC_B3 = 4'b1000
  } ppvc_bstate_t;
endpackage

/* File: ppvc_regs.sv */
// Power-management bridge extension, power data and product-data capability registers.
// Notes on behaviour
// - Bit 7 of bridge extension is read-only secondary bus control enable, resets 0.
// - With enable clear, power-state writes never alter secondary bus power or clock.
// - Action bit 1 means D3hot stops the secondary clock, state B2.
// - Action bit 0 means D3hot removes secondary power, state B3.
// - The D3hot action bit is ignored unless the enable bit reads 1.
// - D0 gives B0, D1 gives B1, D2 gives B2 clock stopped, D3cold B3.
// - D3hot enters B2 or B3 per action bit; power removed only in B3.
// - Bridge extension bits 5 to 0 read zero; whole byte ignores writes.
// - Power data byte is read-only, resets 00h, reports selected quantity; the code samples meas_value whatever dsel holds.
// - Power data is interpreted with the reported data scale field.
// - Product-data identifier byte always reads 03h and is read-only.
// - Product-data next pointer is read-only and reads 00h.
// - Identifier at 8h, next at 9h, address at Ah, data word at Ch.
// - Power state codes D0..D3hot; unsupported state writes complete, change nothing.
// - Four-bit data select chooses what power data and scale report; here dsel is only stored and read back, selecting nothing.
// - Address register carries a completion flag for storage transfers.
`timescale 1ns/1ps
`include "ppvc_params.svh"
module ppvc_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire ppvc_pkg::ppvc_req_t req,
  input wire logic [7:0] bridge_strap,
  input wire logic [3:0] ps_supported,
  input wire logic [7:0] meas_value,
  input wire logic [1:0] meas_scale,
  input wire logic xfer_done,
  input wire logic [31:0] store_rdata,
  output logic [31:0] rdata,
  output logic ack,
  output logic [1:0] power_state,
  output ppvc_pkg::ppvc_sec_t sec_bus,
  output logic xfer_start,
  output logic xfer_write,
  output logic [6:0] xfer_addr,
  output logic [31:0] xfer_wdata
);
  import ppvc_pkg::*;

  // Strap for the bridge extension captured once after reset release.
  logic [7:0] bse;
  logic strap_taken;
  logic [1:0] ps;
  logic [3:0] dsel;
  logic [7:0] data_val;
  logic [1:0] dscale;
  logic [15:0] addr_reg;
  logic [31:0] word_reg;
  logic busy;

  // Word-level offset decoding.
  wire hit_pm = (req.offset == `PPVC_OFF_PM_CONTROL_STATUS);
  wire hit_cap = (req.offset == `PPVC_OFF_CAPID);
  wire hit_word = (req.offset == `PPVC_OFF_WORD);
  wire wr_pm = req.wr && hit_pm;
  wire wr_cap = req.wr && hit_cap;
  wire wr_word = req.wr && hit_word;

  // Power-state write is accepted only for a supported state code.
  wire [1:0] ps_new = req.wdata[`PPVC_PS_HI:`PPVC_PS_LO];
  wire ps_ok = wr_pm && req.byte_en[0] && ps_supported[ps_new];
  wire [3:0] dsel_new = req.wdata[`PPVC_DSEL_HI:`PPVC_DSEL_LO];
  // Read-only bytes are never write targets.
  wire addr_wr = wr_cap && req.byte_en[2] && req.byte_en[3] && !busy;

  // Bridge extension fields.
  // Enable bit.
  wire secondary_bus_ctrl_enable = bse[`PPVC_BIT_BPCC];
  wire b2b3 = bse[`PPVC_BIT_B2B3];

  // Map of the function state to the secondary bus state.
  function automatic ppvc_sec_t map_sec(input logic [1:0] st, input logic en,
                                        input logic act);
    ppvc_sec_t s;
    s = '0;
    s.bus_state = st;
    if (!en) begin
      s.bus_state = 2'h0;
    end else if (st == `PPVC_PS_D2) begin
      s.clock_stop = 1'b1;
    end else if (st == `PPVC_PS_D3) begin
      s.clock_stop = 1'b1;
      s.power_off = !act;
      s.bus_state = act ? 2'h2 : 2'h3;
    end
    return s;
  endfunction

  wire ppvc_sec_t next_sec = map_sec(ps, secondary_bus_ctrl_enable, b2b3);

  // Read data assembly per word.
  // Reserved bits zero.
  wire [7:0] bse_rd = {bse[7:6], 6'h00};
  wire [15:0] pm_lo = {1'b0, dscale, dsel, 7'h00, ps};
  wire [31:0] next_rdata =
    hit_pm ? {data_val, bse_rd, pm_lo} :
    hit_cap ? {addr_reg, `PPVC_NEXT_VAL, `PPVC_CAPID_VAL} :
    hit_word ? word_reg : 32'h0000_0000;

  // Strap capture and bridge extension byte.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bse <= `PPVC_BSE_RST;
      strap_taken <= 1'b0;
    end else if (clk_en && !strap_taken) begin
      bse <= bridge_strap;
      strap_taken <= 1'b1;
    end
  end

  // Power state and data select.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ps <= `PPVC_PS_D0;
      dsel <= 4'h0;
    end else if (clk_en) begin
      if (ps_ok) begin
        ps <= ps_new;
      end
      if (wr_pm && req.byte_en[1]) begin
        dsel <= dsel_new;
      end
    end
  end

  // Power data and its scale sampled from meas_value and meas_scale every enabled cycle, whatever dsel holds.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_val <= `PPVC_DATA_RST;
      dscale <= 2'h0;
    end else if (clk_en) begin
      data_val <= meas_value;
      dscale <= meas_scale;
    end
  end

  // Product-data address register and storage handshake.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 16'h0000;
      busy <= 1'b0;
      xfer_start <= 1'b0;
      xfer_write <= 1'b0;
    end else if (clk_en) begin
      xfer_start <= addr_wr;
      if (addr_wr) begin
        // Flag written 1 requests a write, 0 a read; it flips when done.
        addr_reg <= req.wdata[31:16];
        xfer_write <= req.wdata[16 + `PPVC_FLAG_BIT];
        busy <= 1'b1;
      end else if (busy && xfer_done) begin
        addr_reg[`PPVC_FLAG_BIT] <= !xfer_write;
        busy <= 1'b0;
      end
    end
  end

  // Data word: loaded by software or by a finished read.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      if (busy && xfer_done && !xfer_write) begin
        word_reg <= store_rdata;
      end else if (wr_word && !busy) begin
        word_reg <= req.wdata;
      end
    end
  end

  // Registered outputs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
      ack <= 1'b0;
      power_state <= `PPVC_PS_D0;
      sec_bus <= '0;
      xfer_addr <= 7'h00;
      xfer_wdata <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata <= req.rd ? next_rdata : 32'h0000_0000;
      ack <= req.rd || req.wr;
      power_state <= ps;
      sec_bus <= next_sec;
      // The storage address follows a new address write in the same cycle as the start pulse.
      xfer_addr <= addr_wr ? req.wdata[22:16] : addr_reg[6:0];
      xfer_wdata <= word_reg;
    end
  end
endmodule

/* File: ppvc_store_model.sv */
// Behavioural storage component that answers product-data transfers.
`timescale 1ns/1ps
module ppvc_store_model (
  input wire logic clk,
  input wire logic [3:0] dly,
  input wire logic xfer_start,
  input wire logic xfer_write,
  input wire logic [6:0] xfer_addr,
  input wire logic [31:0] xfer_wdata,
  output logic xfer_done,
  output logic [31:0] store_rdata
);
  logic [31:0] mem [128];
  initial begin
    xfer_done = 1'b0;
    store_rdata = 32'h0;
  end
  // Each transfer ends after a chosen delay with a one-cycle done pulse.
  always @(posedge clk) begin
    if (xfer_start) begin
      repeat (dly) @(posedge clk);
      if (xfer_write) mem[xfer_addr] = xfer_wdata;
      xfer_done <= 1'b1;
      store_rdata <= mem[xfer_addr];
      @(posedge clk);
      xfer_done <= 1'b0;
      store_rdata <= ~store_rdata; // Stale data is not left on the lines.
    end
  end
endmodule

/* File: ppvc_regs_checker.sv */
// Concurrent checks on the capability register bank ports.
`timescale 1ns/1ps
module ppvc_regs_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire ppvc_pkg::ppvc_req_t req,
  input wire logic [7:0] bridge_strap,
  input wire logic [3:0] ps_supported,
  input wire logic [7:0] meas_value,
  input wire logic [1:0] meas_scale,
  input wire logic [31:0] rdata,
  input wire logic ack,
  input wire logic [1:0] power_state,
  input wire ppvc_pkg::ppvc_sec_t sec_bus,
  input wire logic xfer_start,
  input wire logic [6:0] xfer_addr
);
  import ppvc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Requests and their answers.
  sequence s_rd(o);
    clk_en && req.rd && req.offset == o;
  endsequence
  property p_ack; clk_en && (req.rd || req.wr) |=> ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_capid; s_rd(4'h8) |=> rdata[15:0] == 16'h0003; endproperty
  a_capid: assert property (p_capid) else $error("bad id word");
  property p_pmw; s_rd(4'h4) |=> rdata[21:16] == 6'h0 && rdata[31:24] == meas_value
    && rdata[14:13] == meas_scale; endproperty
  a_pmw: assert property (p_pmw) else $error("bad power word");
  property p_off; !bridge_strap[7] |-> sec_bus == 4'h0; endproperty
  a_off: assert property (p_off) else $error("bus moved while disabled");
  property p_d2; (bridge_strap[7] && power_state == 2'h2)[*3] |-> sec_bus == 4'ha; endproperty
  a_d2: assert property (p_d2) else $error("bad state for D2");
  property p_d3; (bridge_strap[7] && power_state == 2'h3)[*3] |->
    sec_bus == (bridge_strap[6] ? 4'ha : 4'hf); endproperty
  a_d3: assert property (p_d3) else $error("bad state for D3hot");
  property p_ps; power_state != $past(power_state) |-> ps_supported[power_state]; endproperty
  a_ps: assert property (p_ps) else $error("unsupported state taken");
  property p_start; clk_en && req.wr && req.offset == 4'h8 && req.byte_en[3:2] == 2'b11
    |=> xfer_start && xfer_addr == $past(req.wdata[22:16]); endproperty
  a_start: assert property (p_start) else $error("transfer not started");
endmodule
bind ppvc_regs ppvc_regs_checker i_ppvc_regs_checker (.clk, .rst_n, .clk_en, .req, .bridge_strap,
  .ps_supported, .meas_value, .meas_scale, .rdata, .ack, .power_state, .sec_bus, .xfer_start,
  .xfer_addr);

/* File: testbench.sv */
// Self-checking bench for the capability register bank.
`timescale 1ns/1ps
module testbench;
  import ppvc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  ppvc_req_t req = '0;
  logic [7:0] strap = 8'h0;
  logic [3:0] dly = 4'h2;
  logic [7:0] meas = 8'h5c;
  logic [1:0] scl = 2'h2;
  logic xfer_done, ack, xfer_start, xfer_write;
  logic [31:0] store_rdata, rdata, xfer_wdata, d;
  logic [1:0] power_state;
  logic [6:0] xfer_addr;
  ppvc_sec_t sec_bus;
  int n_errors = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  ppvc_regs i_ppvc_regs (.clk, .rst_n, .clk_en, .req, .bridge_strap(strap), .ps_supported(4'hd),
    .meas_value(meas), .meas_scale(scl), .xfer_done, .store_rdata, .rdata, .ack, .power_state,
    .sec_bus, .xfer_start, .xfer_write, .xfer_addr, .xfer_wdata);
  ppvc_store_model i_ppvc_store_model (.clk, .dly, .xfer_start, .xfer_write, .xfer_addr,
    .xfer_wdata, .xfer_done, .store_rdata);
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One configuration access; the answer lands in d.
  task automatic acc(logic w, logic [3:0] o, logic [3:0] be, logic [31:0] wd);
    @(posedge clk);
    req <= {w, ~w, o, be, wd};
    @(posedge clk);
    req <= '0;
    #1;
    check("ack", ack, 1'b1);
    d = rdata;
  endtask
  function automatic logic [3:0] exp_sec(logic [1:0] p);
    if (!strap[7]) return 4'h0;
    if (p == 2'h3) return strap[6] ? 4'ha : 4'hf;
    return (p == 2'h2) ? 4'ha : {2'b00, p};
  endfunction
  task automatic t_power(logic [7:0] s);
    logic [1:0] cur;
    cur = 2'h0;
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b1, 4'h4, 4'h4, 32'h00ff_0000);
    acc(1'b0, 4'h4, 4'hf, 32'h0);
    check("bridge byte", d[23:16], s & 8'hc0);
    for (int p = 0; p < 4; p++) begin
      acc(1'b1, 4'h4, 4'h1, 32'(p));
      if (p != 1) cur = 2'(p);
      repeat (3) @(posedge clk);
      #1;
      check("power state", power_state, cur);
      check("secondary bus", sec_bus, exp_sec(cur));
    end
    $display("power test done %h", s);
  endtask
  task automatic t_fixed;
    acc(1'b1, 4'h8, 4'h3, 32'hffff_ffff);
    acc(1'b0, 4'h8, 4'hf, 32'h0);
    check("id word", d[15:0], 16'h0003);
    acc(1'b0, 4'h4, 4'hf, 32'h0);
    check("power data", d[31:24], meas);
    check("data scale", d[14:13], scl);
    $display("fixed bytes test done");
  endtask
  task automatic wait_flag(logic f);
    int k;
    k = 0;
    do begin
      acc(1'b0, 4'h8, 4'hf, 32'h0);
      k++;
    end while (d[31] !== f && k < 20);
    check("flag", d[31], f);
  endtask
  task automatic t_product;
    acc(1'b1, 4'hc, 4'hf, 32'hc0ff_ee11);
    acc(1'b1, 4'h8, 4'hc, 32'h8015_0000);
    wait_flag(1'b0);
    dly <= 4'h7;
    acc(1'b1, 4'hc, 4'hf, 32'h0);
    acc(1'b1, 4'h8, 4'hc, 32'h0015_0000);
    wait_flag(1'b1);
    check("address", d[22:16], 7'h15);
    acc(1'b0, 4'hc, 4'hf, 32'h0);
    check("data word", d, 32'hc0ff_ee11);
    $display("product data test done");
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence; each power pass starts with its own reset.
  initial begin
    t_power(8'h7f);
    t_fixed;
    t_product;
    t_power(8'hc0);
    t_power(8'h80);
    summarize;
  end
  // Watchdog that ends a hung run.
  initial begin
    #200000;
    n_errors++;
    $display("Error watchdog expired");
    summarize;
  end
endmodule
